// [src/hic_count_merge.sv]
// Purpose: Drops one 12-bit byte count into the 96-bit count image
// Assumes: Image is {dw7,dw6,dw5}; fields may straddle the dword seams
// Notes: Purely combinational; untouched fields pass through unchanged
`timescale 1ns/1ps
`default_nettype none
module hic_count_merge (
  input wire logic [95:0] image_in,
  input wire logic [2:0] idx_in,
  input wire logic [11:0] count_in,
  input wire logic wr_in,
  output logic [95:0] image_out
);
  logic [6:0] lsb;

  always_comb begin
    lsb = hic_pkg::field_lsb(idx_in);
    image_out = image_in;
    // One shift covers the split fields too, since the image is contiguous
    if (wr_in) begin
      image_out[lsb +: hic_pkg::COUNT_W] = count_in;
    end
  end
endmodule
`default_nettype wire

// [src/hic_isoc_writeback.sv]
// Purpose: Isochronous IN byte-count write-back into transfer descriptor dwords 4..7
// Assumes: Packet engine pulses uframe_done_in once per processed microframe
// Notes: Avalon-MM slave, one wait cycle per access; hardware count writes beat software
// Contract
// [RULE1] Microframe 7 count goes to dword 7 bits 63:52 when active and frame matches.
// [RULE2] Microframe 6 count goes to dword 7 bits 51:40 when active and frame matches.
// [RULE3] Microframe 5 count split: high byte dword 7 bits 39:32, low nibble dword 6 31:28.
// [RULE4] Microframe 4 count goes to dword 6 bits 27:16 when active and frame matches.
// [RULE5] Microframe 3 count goes to dword 6 bits 15:4 when active and frame matches.
// [RULE6] Microframe 2 count split: high nibble dword 6 bits 3:0, low byte dword 5 63:56.
// [RULE7] Microframe 1 count goes to dword 5 bits 55:44 when active and frame matches.
// [RULE8] Microframe 0 count goes to dword 5 bits 43:32 when active and frame matches.
// [RULE9] Active bits checked before sending on frame match, cleared after processing.
// [RULE10] Three-bit result per microframe: error, babble on IN, underrun on OUT.
// [RULE11] Inactive or mismatched microframes leave their count fields untouched.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hic_isoc_writeback (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [4:0] bus_frame_in,
  input wire logic [2:0] uframe_idx_in,
  input wire logic uframe_done_in,
  input wire logic [11:0] rx_count_in,
  input wire logic [2:0] result_flags_in,
  input wire logic token_out_in,
  output logic uframe_send_out,
  output logic irq_out
);
  logic [31:0] dw2_r;
  logic [63:0] desc_a_r;
  logic [63:0] desc_b_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic send_r;
  logic [2:0] last_idx_r;

  logic bus_req;
  logic bus_wr;
  logic frame_match;
  logic [7:0] active_bits;
  logic [7:0] hit_v;
  logic hit;
  logic skip;
  logic [2:0] rec_flags;
  logic [63:0] a_sw;
  logic [63:0] b_sw;
  logic [95:0] img_sw;
  logic [95:0] img_nxt;
  logic [31:0] dw4_nxt;
  logic [2:0] ev;

  assign bus_req = avs_read_in | avs_write_in;
  // Writes land only on the edge that completes the transfer
  assign bus_wr = avs_write_in & ack_r;
  assign avs_waitrequest_out = bus_req & ~ack_r;
  assign avs_readdata_out = rdata_r;
  assign uframe_send_out = send_r;
  assign irq_out = |(irq_stat_r & irq_mask_r);

  function automatic logic wr_hit(input logic [3:0] idx, input logic we, input logic [3:0] a);
    wr_hit = we & (a == idx);
  endfunction

  assign frame_match = dw2_r[hic_pkg::DW2_FRAME_LSB +: hic_pkg::FRAME_W] == bus_frame_in;
  assign active_bits = desc_a_r[hic_pkg::DW4_ACT_LSB +: hic_pkg::UF_N];

  // Per-microframe write-back qualifier
  genvar g;
  generate
    for (g = 0; g < hic_pkg::UF_N; g++) begin : g_hit
      assign hit_v[g] = uframe_done_in & (uframe_idx_in == 3'(g)) & active_bits[g]
                        & frame_match; // RULE11
    end
  endgenerate
  assign hit = |hit_v;
  assign skip = uframe_done_in & ~hit;

  // Babble only counts for IN, underrun only for OUT
  always_comb begin
    rec_flags = 3'h0;
    rec_flags[hic_pkg::FLAG_XACT_ERR] = result_flags_in[hic_pkg::FLAG_XACT_ERR]; // RULE10
    rec_flags[hic_pkg::FLAG_BABBLE] = result_flags_in[hic_pkg::FLAG_BABBLE] & ~token_out_in;
    rec_flags[hic_pkg::FLAG_UNDERRUN] = result_flags_in[hic_pkg::FLAG_UNDERRUN] & token_out_in;
  end

  // Software writes first, hardware results laid over them
  always_comb begin
    a_sw = desc_a_r;
    b_sw = desc_b_r;
    if (wr_hit(hic_pkg::REG_DW4, bus_wr, avs_address_in)) begin
      a_sw[31:0] = hic_pkg::be_merge(desc_a_r[31:0], avs_writedata_in, avs_byteenable_in);
    end
    if (wr_hit(hic_pkg::REG_DW5, bus_wr, avs_address_in)) begin
      a_sw[63:32] = hic_pkg::be_merge(desc_a_r[63:32], avs_writedata_in, avs_byteenable_in);
    end
    if (wr_hit(hic_pkg::REG_DW6, bus_wr, avs_address_in)) begin
      b_sw[31:0] = hic_pkg::be_merge(desc_b_r[31:0], avs_writedata_in, avs_byteenable_in);
    end
    if (wr_hit(hic_pkg::REG_DW7, bus_wr, avs_address_in)) begin
      b_sw[63:32] = hic_pkg::be_merge(desc_b_r[63:32], avs_writedata_in, avs_byteenable_in);
    end
    img_sw = {b_sw, a_sw[63:32]};
  end

  hic_count_merge u_merge (
    .image_in(img_sw),
    .idx_in(uframe_idx_in),
    .count_in(rx_count_in),
    .wr_in(hit), // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
    .image_out(img_nxt)
  );

  // Active bit clear loses to a software write of the same byte
  always_comb begin
    dw4_nxt = a_sw[31:0];
    if (hit) begin
      dw4_nxt[hic_pkg::DW4_STAT_LSB + 3 * uframe_idx_in +: hic_pkg::FLAG_W] = rec_flags; // RULE10
      if (!(wr_hit(hic_pkg::REG_DW4, bus_wr, avs_address_in) && avs_byteenable_in[0])) begin
        dw4_nxt[uframe_idx_in] = 1'b0; // RULE9
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      desc_a_r <= {hic_pkg::REG_RESET, hic_pkg::REG_RESET};
      desc_b_r <= {hic_pkg::REG_RESET, hic_pkg::REG_RESET};
    end else begin
      desc_b_r <= img_nxt[95:32];
      desc_a_r <= {img_nxt[31:0], dw4_nxt};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dw2_r <= hic_pkg::REG_RESET;
    end else if (wr_hit(hic_pkg::REG_DW2, bus_wr, avs_address_in)) begin
      dw2_r <= hic_pkg::be_merge(dw2_r, avs_writedata_in, avs_byteenable_in);
    end
  end

  // Go/no-go for the packet engine, sampled ahead of the microframe
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      send_r <= 1'b0;
    end else begin
      send_r <= active_bits[uframe_idx_in] & frame_match; // RULE9
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      last_idx_r <= 3'h0;
    end else if (uframe_done_in) begin
      last_idx_r <= uframe_idx_in;
    end
  end

  assign ev = {skip, hit & (|rec_flags), hit};

  // Sticky events: a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_stat_r <= hic_pkg::EV_RESET;
    end else if (wr_hit(hic_pkg::REG_IRQ_STAT, bus_wr, avs_address_in) && avs_byteenable_in[0]) begin
      irq_stat_r <= (irq_stat_r & ~avs_writedata_in[2:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_mask_r <= hic_pkg::EV_RESET;
    end else if (wr_hit(hic_pkg::REG_IRQ_MASK, bus_wr, avs_address_in) && avs_byteenable_in[0]) begin
      irq_mask_r <= avs_writedata_in[2:0];
    end
  end

  // One wait cycle; read data captured on the first request cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_r <= hic_pkg::REG_RESET;
    end else if (avs_read_in && !ack_r) begin
      case (avs_address_in)
        hic_pkg::REG_DW2: rdata_r <= dw2_r;
        hic_pkg::REG_DW4: rdata_r <= desc_a_r[31:0];
        hic_pkg::REG_DW5: rdata_r <= desc_a_r[63:32];
        hic_pkg::REG_DW6: rdata_r <= desc_b_r[31:0];
        hic_pkg::REG_DW7: rdata_r <= desc_b_r[63:32];
        hic_pkg::REG_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
        hic_pkg::REG_IRQ_MASK: rdata_r <= {29'h0, irq_mask_r};
        hic_pkg::REG_INFO: rdata_r <= {21'h0, last_idx_r, 3'h0, bus_frame_in};
        default: rdata_r <= hic_pkg::REG_RESET;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  logic sw_desc_wr;
  assign sw_desc_wr = bus_wr && (avs_address_in >= hic_pkg::REG_DW5)
                      && (avs_address_in <= hic_pkg::REG_DW7);

  uf7_count_a: assert property (hit_v[7] |=> desc_b_r[63:52] == $past(rx_count_in)) // RULE1
    else $error("uframe 7 count not written");
  uf6_count_a: assert property (hit_v[6] |=> desc_b_r[51:40] == $past(rx_count_in)) // RULE2
    else $error("uframe 6 count not written");
  uf5_split_a: assert property (hit_v[5] |=> {desc_b_r[39:32], desc_b_r[31:28]} // RULE3
                                == $past(rx_count_in))
    else $error("uframe 5 split count wrong");
  uf4_count_a: assert property (hit_v[4] |=> desc_b_r[27:16] == $past(rx_count_in)) // RULE4
    else $error("uframe 4 count not written");
  uf3_count_a: assert property (hit_v[3] |=> desc_b_r[15:4] == $past(rx_count_in)) // RULE5
    else $error("uframe 3 count not written");
  uf2_split_a: assert property (hit_v[2] |=> {desc_b_r[3:0], desc_a_r[63:56]} // RULE6
                                == $past(rx_count_in))
    else $error("uframe 2 split count wrong");
  uf1_count_a: assert property (hit_v[1] |=> desc_a_r[55:44] == $past(rx_count_in)) // RULE7
    else $error("uframe 1 count not written");
  uf0_count_a: assert property (hit_v[0] |=> desc_a_r[43:32] == $past(rx_count_in)) // RULE8
    else $error("uframe 0 count not written");

  active_clear_a: assert property (hit && !wr_hit(hic_pkg::REG_DW4, bus_wr, avs_address_in) // RULE9
                                   |=> !desc_a_r[$past(uframe_idx_in)])
    else $error("active bit not cleared after processing");
  send_gate_a: assert property (##1 send_r == $past(active_bits[uframe_idx_in] // RULE9
                                                   & frame_match))
    else $error("send decision does not follow active bit and frame");
  babble_in_a: assert property (hit && token_out_in |=> // RULE10
                                !desc_a_r[hic_pkg::DW4_STAT_LSB + 3 * $past(uframe_idx_in)
                                          + hic_pkg::FLAG_BABBLE])
    else $error("babble recorded on an OUT microframe");
  keep_count_a: assert property (skip && !sw_desc_wr |=> // RULE11
                                 {desc_b_r, desc_a_r[63:32]} == $past({desc_b_r, desc_a_r[63:32]}))
    else $error("count image changed on skipped microframe");

  sequence bus_req_s;
    bus_req && !ack_r;
  endsequence
  sequence bus_done_s;
    !avs_waitrequest_out ##1 !ack_r;
  endsequence
  bus_ack_a: assert property (bus_req_s |=> bus_done_s)
    else $error("bus answer not one cycle after request");
endmodule
`default_nettype wire

// [src/hic_pkg.sv]
// Purpose: Constants for the isochronous IN byte-count write-back block
// Assumes: Descriptor dwords 4..7 held as two 64-bit words, {dw5,dw4} and {dw7,dw6}
// Notes: Count image is {dw7,dw6,dw5} as one 96-bit vector, microframe 0 at bit 0
package hic_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int UF_N = 8;
  localparam int COUNT_W = 12;
  localparam int FLAG_W = 3;
  localparam int FRAME_W = 5;
  localparam int IMG_W = 96;
  localparam int LSB_W = 7;
  // Register word indexes on the Avalon slave
  localparam logic [3:0] REG_DW2 = 4'h0;
  localparam logic [3:0] REG_DW4 = 4'h1;
  localparam logic [3:0] REG_DW5 = 4'h2;
  localparam logic [3:0] REG_DW6 = 4'h3;
  localparam logic [3:0] REG_DW7 = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;
  localparam logic [3:0] REG_INFO = 4'h7;
  // Descriptor field positions
  localparam int DW2_FRAME_LSB = 3;
  localparam int DW4_ACT_LSB = 0;
  localparam int DW4_STAT_LSB = 8;
  localparam int FLAG_XACT_ERR = 0;
  localparam int FLAG_BABBLE = 1;
  localparam int FLAG_UNDERRUN = 2;
  // Count field LSBs inside the 96-bit image
  localparam logic [6:0] UF0_LSB = 7'h00;
  localparam logic [6:0] UF1_LSB = 7'h0C;
  localparam logic [6:0] UF2_LSB = 7'h18;
  localparam logic [6:0] UF3_LSB = 7'h24;
  localparam logic [6:0] UF4_LSB = 7'h30;
  localparam logic [6:0] UF5_LSB = 7'h3C;
  localparam logic [6:0] UF6_LSB = 7'h48;
  localparam logic [6:0] UF7_LSB = 7'h54;
  // Interrupt event bits
  localparam int EV_WRITTEN = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_SKIPPED = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] EV_RESET = 3'h0;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  function automatic logic [6:0] field_lsb(input logic [2:0] idx);
    case (idx)
      3'h0: field_lsb = UF0_LSB;
      3'h1: field_lsb = UF1_LSB;
      3'h2: field_lsb = UF2_LSB;
      3'h3: field_lsb = UF3_LSB;
      3'h4: field_lsb = UF4_LSB;
      3'h5: field_lsb = UF5_LSB;
      3'h6: field_lsb = UF6_LSB;
      default: field_lsb = UF7_LSB;
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction
endpackage

// [test/hic_dev_model.sv]
// Purpose: Behavioural isochronous device reporting finished microframes
// Assumes: Tasks are entered right after a rising clock edge
// Notes: Between pulses the data lines carry inverted values, never stale ones
`timescale 1ns/1ps
`default_nettype none
module hic_dev_model (
  input wire logic clk_in,
  output logic [2:0] uframe_idx_out,
  output logic uframe_done_out,
  output logic [11:0] rx_count_out,
  output logic [2:0] result_flags_out,
  output logic token_out_out
);
  initial begin
    uframe_idx_out = 3'h0;
    uframe_done_out = 1'b0;
    rx_count_out = 12'h000;
    result_flags_out = 3'h0;
    token_out_out = 1'b0;
  end

  task automatic finish_uframe(input logic [2:0] idx, input logic [11:0] cnt,
                               input logic [2:0] flags, input logic tok);
    uframe_idx_out <= idx;
    uframe_done_out <= 1'b1;
    rx_count_out <= cnt;
    result_flags_out <= flags;
    token_out_out <= tok;
    @(posedge clk_in);
    uframe_done_out <= 1'b0;
    rx_count_out <= ~cnt;
    result_flags_out <= ~flags;
    token_out_out <= ~tok;
    // Spacer edge so the pulse is never re-raised in the same step
    @(posedge clk_in);
  endtask

  task automatic point_at(input logic [2:0] idx);
    uframe_idx_out <= idx;
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Purpose: Self-checking bench for the isochronous count write-back block
// Assumes: One wait cycle per Avalon access; master waits for it anyway
// Notes: Expected count image built from 12-bit fields at k*12 in {dw7,dw6,dw5}
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] bus_frame = 5'h05;
  logic [2:0] idx;
  logic done;
  logic [11:0] cnt;
  logic [2:0] flags;
  logic tok;
  logic send;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;
  logic [11:0] cnts [8] = '{12'hABC, 12'h123, 12'hF5A, 12'h0E7, 12'h9D4, 12'h36B, 12'hC08, 12'h7F1};
  logic [95:0] img;
  logic [31:0] dw4;
  logic [31:0] q;

  hic_isoc_writeback hic_isoc_writeback_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .bus_frame_in(bus_frame),
    .uframe_idx_in(idx), .uframe_done_in(done), .rx_count_in(cnt),
    .result_flags_in(flags), .token_out_in(tok), .uframe_send_out(send), .irq_out(irq)
  );

  hic_dev_model dev_i (
    .clk_in(clk_in), .uframe_idx_out(idx), .uframe_done_out(done),
    .rx_count_out(cnt), .result_flags_out(flags), .token_out_out(tok)
  );

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Entered just after a rising edge; waitrequest judged at each rising edge
  // No cycle count assumed: only the watchdog ends a stuck wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic dwords_chk();
    rd_chk(hic_pkg::REG_DW5, img[31:0]);
    rd_chk(hic_pkg::REG_DW6, img[63:32]);
    rd_chk(hic_pkg::REG_DW7, img[95:64]);
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    img = 96'h0;
    dwords_chk();
    bus(1'b1, 4'hF, 32'hFFFF_FFFF);
    rd_chk(4'hF, 32'h0);
    bus(1'b1, hic_pkg::REG_DW2, 32'h0000_0028);
    rd_chk(hic_pkg::REG_DW2, 32'h0000_0028);
    bus(1'b1, hic_pkg::REG_DW4, 32'h0000_00FF);
    bus(1'b1, hic_pkg::REG_IRQ_MASK, 32'h0000_0007);
    // Every microframe, odd ones as OUT, all flags raised
    dw4 = 32'h0;
    for (int k = 0; k < 8; k++) begin
      dev_i.finish_uframe(3'(k), cnts[k], 3'h7, k[0]);
      img[k*12 +: 12] = cnts[k];
      dw4[8 + 3*k +: 3] = k[0] ? 3'b101 : 3'b011;
    end
    dwords_chk();
    rd_chk(hic_pkg::REG_DW4, dw4);
    rd_chk(hic_pkg::REG_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, hic_pkg::REG_IRQ_STAT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    // Active bit already cleared: field must hold
    dev_i.finish_uframe(3'h3, 12'h555, 3'h0, 1'b0);
    dwords_chk();
    rd_chk(hic_pkg::REG_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, hic_pkg::REG_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Frame mismatch with active bit set: nothing written
    bus(1'b1, hic_pkg::REG_DW4, 32'h0000_0010);
    bus_frame <= 5'h06;
    dev_i.finish_uframe(3'h4, 12'hAAA, 3'h0, 1'b0);
    dwords_chk();
    rd_chk(hic_pkg::REG_DW4, 32'h10);
    chk({31'h0, send}, 32'h0);
    bus_frame <= 5'h05;
    repeat (2) @(posedge clk_in);
    chk({31'h0, send}, 32'h1);
    dev_i.point_at(3'h5);
    repeat (2) @(posedge clk_in);
    chk({31'h0, send}, 32'h0);
    // Last finished microframe was 4, bus frame back at 5
    rd_chk(hic_pkg::REG_INFO, 32'h0000_0405);
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk_in);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
